// ===== include/cfg_space_pkg.sv
// configuration-space register bank constants: offsets, fields, reset values
// assumes nothing beyond a SystemVerilog compiler; shared by the register bank and the testbench
package cfg_space_pkg;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_ID = 8'h00;
   localparam logic [7:0] OFF_CMDSTAT = 8'h04;
   localparam logic [7:0] OFF_REV = 8'h08;
   localparam logic [7:0] OFF_LAT = 8'h0C;
   localparam logic [7:0] OFF_IOBASE = 8'h10;
   localparam logic [7:0] OFF_MEMBASE = 8'h14;
   localparam logic [7:0] OFF_RSVD_LO = 8'h18;
   localparam logic [7:0] OFF_RSVD_HI = 8'h38;
   localparam logic [7:0] OFF_INTR = 8'h3C;
   localparam logic [7:0] OFF_DRV = 8'h40;

   // ****************************************
   // identification (values arbitrary, not of any real part)
   // ****************************************
   localparam logic [15:0] DEVICE_ID = 16'h0A5A; // arbitrary value
   localparam logic [15:0] VENDOR_ID = 16'h1234; // arbitrary value

   // ****************************************
   // command/status field positions
   // ****************************************
   localparam int BIT_IOEN = 0;
   localparam int BIT_MEMEN = 1;
   localparam int BIT_MASTEREN = 2;
   localparam int BIT_PERRRESP = 6;
   localparam int BIT_SERREN = 8;
   localparam int BIT_FASTB2B = 23;
   localparam int BIT_DATAPAR = 24;
   localparam int BIT_DEVSEL_LO = 25;
   localparam int BIT_RXTABORT = 28;
   localparam int BIT_RXMABORT = 29;
   localparam int BIT_SIGSERR = 30;
   localparam int BIT_DETPERR = 31;
   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   localparam logic [31:0] CMDSTAT_RESET = 32'h02800000;

   // ****************************************
   // reset values of the other registers
   // ****************************************
   localparam logic [31:0] REV_VALUE = 32'h02000011;
   localparam logic [31:0] LAT_RESET = 32'h00000000;
   localparam logic [7:0] INTR_PIN = 8'h01;
   localparam logic [31:0] ZERO32 = 32'h00000000;
   localparam logic [31:0] IOBASE_RESET = 32'h00000001;

   // ****************************************
   // writable bits of the stored words and field positions
   // ****************************************
   localparam logic [31:0] LAT_WR_MASK = 32'h0000FF00;
   localparam logic [31:0] IOBASE_WR_MASK = 32'hFFFFFF80;
   localparam logic [31:0] MEMBASE_WR_MASK = 32'hFFFFFF80;
   localparam logic [31:0] INTR_WR_MASK = 32'h000000FF;
   localparam logic [31:0] DRV_WR_MASK = 32'hFFFFFFFF;
   localparam int LAT_FIELD_LO = 8;
endpackage

// ===== rtl/cfg_byte_lane.sv
// one byte lane of a writable configuration register, with a write mask
// assumes the caller supplies this lane's byte of the whole-word reset value
module cfg_byte_lane (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // write side
   input wire logic wrEn,
   input wire logic [7:0] wrData,
   input wire logic [7:0] wrMask,
   input wire logic [7:0] resetVal,
   // stored value
   output logic [7:0] laneQ
);
   // masked bits keep their value, so read-only bits never move
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         laneQ <= resetVal;
      end else if (wrEn) begin
         laneQ <= (laneQ & ~wrMask) | (wrData & wrMask);
      end
   end
endmodule

// ===== rtl/pci_config_space_regs.sv
// configuration-space register bank of a fast Ethernet controller
// assumes the bus interface decodes config cycles and presents one-cycle strobes
// in the mclk domain; event pulses from the bus engine are also in that domain

// ****************************************
// register bank
// ****************************************
module pci_config_space_regs (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // configuration access
   input wire logic cfgWrite,
   input wire logic cfgRead,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   output logic [31:0] cfgRdData,
   output logic cfgAck,
   // bus events
   input wire logic parityErrDetected,
   input wire logic addrParityErr,
   input wire logic perrSeenAsMaster,
   input wire logic masterAbortSeen,
   input wire logic targetAbortSeen,
   // control outputs
   output logic ioSpaceEnable,
   output logic memSpaceEnable,
   output logic busMasterEnable,
   output logic systemErrorDrive,
   output logic hostSysErrSet,
   // decoded register values for the rest of the controller
   output logic [7:0] latencyTimer,
   output logic [31:0] ioBase,
   output logic [31:0] memBase,
   output logic [7:0] interruptLine,
   output logic [31:0] driverArea
);
   // ****************************************
   // decode
   // ****************************************
   logic isCmd;
   logic isLat;
   logic isIo;
   logic isMem;
   logic isIntr;
   logic isDrv;
   // reserved offsets match none of these, so a write there does nothing
   assign isCmd = cfgAddr == cfg_space_pkg::OFF_CMDSTAT;
   assign isLat = cfgAddr == cfg_space_pkg::OFF_LAT;
   assign isIo = cfgAddr == cfg_space_pkg::OFF_IOBASE;
   assign isMem = cfgAddr == cfg_space_pkg::OFF_MEMBASE;
   assign isIntr = cfgAddr == cfg_space_pkg::OFF_INTR;
   assign isDrv = cfgAddr == cfg_space_pkg::OFF_DRV;

   // ****************************************
   // writable word storage, one generate per lane
   // ****************************************
   // index 0 latency, 1 io base, 2 mem base, 3 interrupt, 4 driver area
   logic [31:0] wordQ [5];
   logic [4:0] wordSel;
   logic [31:0] wordMask [5];
   logic [31:0] wordReset [5];
   assign wordSel = {isDrv, isIntr, isMem, isIo, isLat};
   assign wordMask[0] = cfg_space_pkg::LAT_WR_MASK;
   assign wordMask[1] = cfg_space_pkg::IOBASE_WR_MASK;
   assign wordMask[2] = cfg_space_pkg::MEMBASE_WR_MASK;
   assign wordMask[3] = cfg_space_pkg::INTR_WR_MASK;
   assign wordMask[4] = cfg_space_pkg::DRV_WR_MASK;
   assign wordReset[0] = cfg_space_pkg::LAT_RESET;
   assign wordReset[1] = cfg_space_pkg::IOBASE_RESET;
   assign wordReset[2] = cfg_space_pkg::ZERO32;
   assign wordReset[3] = {16'h0000, cfg_space_pkg::INTR_PIN, 8'h00};
   assign wordReset[4] = cfg_space_pkg::ZERO32;

   genvar w;
   genvar b;
   generate
      for (w = 0; w < 5; w++) begin : gWord
         for (b = 0; b < 4; b++) begin : gLane
            // each byte lane only moves when its byte enable is set
            cfg_byte_lane lane (
               .mclk(mclk),
               .rst_n(rst_n),
               .wrEn(cfgWrite && wordSel[w] && cfgByteEn[b]),
               .wrData(cfgWrData[8*b +: 8]),
               .wrMask(wordMask[w][8*b +: 8]),
               .resetVal(wordReset[w][8*b +: 8]),
               .laneQ(wordQ[w][8*b +: 8])
            );
         end
      end
   endgenerate

   // ****************************************
   // command half
   // ****************************************
   logic cmdLoWrite;
   logic cmdHiWrite;
   logic ioEn_q;
   logic memEn_q;
   logic mstEn_q;
   logic perrResp_q;
   logic serrEn_q;
   // each command byte lane moves only under its own byte enable
   assign cmdLoWrite = cfgWrite && isCmd && cfgByteEn[0];
   assign cmdHiWrite = cfgWrite && isCmd && cfgByteEn[1];

   // hardware reset only; the host software reset never reaches here
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ioEn_q <= 1'b0;
         memEn_q <= 1'b0;
         mstEn_q <= 1'b0;
      end else if (cmdLoWrite) begin
         ioEn_q <= cfgWrData[cfg_space_pkg::BIT_IOEN];
         memEn_q <= cfgWrData[cfg_space_pkg::BIT_MEMEN];
         mstEn_q <= cfgWrData[cfg_space_pkg::BIT_MASTEREN];
      end
   end

   // parity checking starts off, so a bus with bad parity still boots
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         perrResp_q <= 1'b0;
      end else if (cmdLoWrite) begin
         perrResp_q <= cfgWrData[cfg_space_pkg::BIT_PERRRESP];
      end
   end

   // system error enable sits alone in the second command byte
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         serrEn_q <= 1'b0;
      end else if (cmdHiWrite) begin
         serrEn_q <= cfgWrData[cfg_space_pkg::BIT_SERREN];
      end
   end

   // ****************************************
   // status flags: set wins over write-one clear
   // ****************************************
   logic statWrite;
   logic [4:0] clrHi;
   logic serrFire;
   logic dataParSet;
   logic detPerrSet;
   logic detPerr_q;
   logic sigSerr_q;
   logic rxMabort_q;
   logic rxTabort_q;
   logic dataPar_q;
   // only the top status byte lane carries clearable flags
   assign statWrite = cfgWrite && isCmd && cfgByteEn[3];
   assign serrFire = serrEn_q && addrParityErr;
   assign dataParSet = perrSeenAsMaster && perrResp_q;
   // address-phase errors count as detected parity errors too
   assign detPerrSet = parityErrDetected || addrParityErr;
   // one clear strobe per flag, each from its own data bit
   assign clrHi[0] = statWrite && cfgWrData[cfg_space_pkg::BIT_DETPERR];
   assign clrHi[1] = statWrite && cfgWrData[cfg_space_pkg::BIT_SIGSERR];
   assign clrHi[2] = statWrite && cfgWrData[cfg_space_pkg::BIT_RXMABORT];
   assign clrHi[3] = statWrite && cfgWrData[cfg_space_pkg::BIT_RXTABORT];
   assign clrHi[4] = statWrite && cfgWrData[cfg_space_pkg::BIT_DATAPAR];

   // detected parity error; reads never touch any flag
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         detPerr_q <= 1'b0;
      end else if (detPerrSet) begin
         detPerr_q <= 1'b1;
      end else if (clrHi[0]) begin
         detPerr_q <= 1'b0;
      end
   end

   // signalled system error; an event in the clear cycle is not lost
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         sigSerr_q <= 1'b0;
      end else if (serrFire) begin
         sigSerr_q <= 1'b1;
      end else if (clrHi[1]) begin
         sigSerr_q <= 1'b0;
      end
   end

   // received master abort on our own transaction
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rxMabort_q <= 1'b0;
      end else if (masterAbortSeen) begin
         rxMabort_q <= 1'b1;
      end else if (clrHi[2]) begin
         rxMabort_q <= 1'b0;
      end
   end

   // received target abort on our own transaction
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rxTabort_q <= 1'b0;
      end else if (targetAbortSeen) begin
         rxTabort_q <= 1'b1;
      end else if (clrHi[3]) begin
         rxTabort_q <= 1'b0;
      end
   end

   // data parity report, gated by parity response in its set term
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         dataPar_q <= 1'b0;
      end else if (dataParSet) begin
         dataPar_q <= 1'b1;
      end else if (clrHi[4]) begin
         dataPar_q <= 1'b0;
      end
   end

   // ****************************************
   // read mux
   // ****************************************
   logic [31:0] cmdStatWord;
   logic [31:0] rdMux;
   always_comb begin
      cmdStatWord = cfg_space_pkg::ZERO32;
      cmdStatWord[cfg_space_pkg::BIT_IOEN] = ioEn_q;
      cmdStatWord[cfg_space_pkg::BIT_MEMEN] = memEn_q;
      cmdStatWord[cfg_space_pkg::BIT_MASTEREN] = mstEn_q;
      cmdStatWord[cfg_space_pkg::BIT_PERRRESP] = perrResp_q;
      cmdStatWord[cfg_space_pkg::BIT_SERREN] = serrEn_q;
      cmdStatWord[cfg_space_pkg::BIT_FASTB2B] = 1'b1;
      cmdStatWord[cfg_space_pkg::BIT_DATAPAR] = dataPar_q;
      cmdStatWord[cfg_space_pkg::BIT_DEVSEL_LO +: 2] = cfg_space_pkg::DEVSEL_MEDIUM;
      cmdStatWord[cfg_space_pkg::BIT_RXTABORT] = rxTabort_q;
      cmdStatWord[cfg_space_pkg::BIT_RXMABORT] = rxMabort_q;
      cmdStatWord[cfg_space_pkg::BIT_SIGSERR] = sigSerr_q;
      cmdStatWord[cfg_space_pkg::BIT_DETPERR] = detPerr_q;
   end

   // reserved and unmapped offsets fall to zero
   always_comb begin
      case (cfgAddr)
         cfg_space_pkg::OFF_ID:
            rdMux = {cfg_space_pkg::DEVICE_ID, cfg_space_pkg::VENDOR_ID};
         cfg_space_pkg::OFF_CMDSTAT: rdMux = cmdStatWord;
         cfg_space_pkg::OFF_REV: rdMux = cfg_space_pkg::REV_VALUE;
         cfg_space_pkg::OFF_LAT: rdMux = wordQ[0];
         cfg_space_pkg::OFF_IOBASE: rdMux = wordQ[1];
         cfg_space_pkg::OFF_MEMBASE: rdMux = wordQ[2];
         cfg_space_pkg::OFF_INTR: rdMux = wordQ[3];
         cfg_space_pkg::OFF_DRV: rdMux = wordQ[4];
         default: rdMux = cfg_space_pkg::ZERO32;
      endcase
   end

   // ****************************************
   // registered answer: one cycle after the strobe
   // ****************************************
   // every access acks, reserved and identification writes too
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfgAck <= 1'b0;
      end else begin
         cfgAck <= cfgRead || cfgWrite;
      end
   end

   // data is zero outside the answer cycle, so a stray sample reads nothing
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         cfgRdData <= cfg_space_pkg::ZERO32;
      end else begin
         cfgRdData <= cfgRead ? rdMux : cfg_space_pkg::ZERO32;
      end
   end

   // ****************************************
   // control outputs, registered
   // ****************************************
   // an all-zero command half drops every enable, leaving config only
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ioSpaceEnable <= 1'b0;
         memSpaceEnable <= 1'b0;
         busMasterEnable <= 1'b0;
      end else begin
         ioSpaceEnable <= ioEn_q;
         memSpaceEnable <= memEn_q;
         busMasterEnable <= mstEn_q;
      end
   end

   // event pulses lag their cause by one cycle, like the status flags
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         systemErrorDrive <= 1'b0;
         hostSysErrSet <= 1'b0;
      end else begin
         systemErrorDrive <= serrFire;
         // without response enabled, parity errors do not disturb the host
         hostSysErrSet <= perrResp_q && detPerrSet;
      end
   end

   // register copies lag storage by one cycle; users see a settled value
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         latencyTimer <= 8'h00;
         ioBase <= cfg_space_pkg::ZERO32;
         memBase <= cfg_space_pkg::ZERO32;
         interruptLine <= 8'h00;
         driverArea <= cfg_space_pkg::ZERO32;
      end else begin
         latencyTimer <= wordQ[0][cfg_space_pkg::LAT_FIELD_LO +: 8];
         ioBase <= wordQ[1];
         memBase <= wordQ[2];
         interruptLine <= wordQ[3][7:0];
         driverArea <= wordQ[4];
      end
   end
endmodule

// ===== tb/cfg_host_model.sv
// host bridge model issuing one configuration cycle at a time
// assumes inputs change at the falling edge and the answer comes one cycle after the take
module cfg_host_model (
   // clock
   input wire logic mclk,
   // request side
   output logic cfgWrite,
   output logic cfgRead,
   output logic [7:0] cfgAddr,
   output logic [3:0] cfgByteEn,
   output logic [31:0] cfgWrData,
   // answer side
   input wire logic [31:0] cfgRdData,
   input wire logic cfgAck
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle bus at time zero
   initial begin
      cfgWrite = 1'b0;
      cfgRead = 1'b0;
      cfgAddr = 8'h00;
      cfgByteEn = 4'h0;
      cfgWrData = 32'h00000000;
   end
   // one strobe cycle, answer sampled one cycle later
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [3:0] be,
                       input logic [31:0] d, output logic [31:0] rd, output logic ok);
      @(negedge mclk);
      cfgWrite = wr;
      cfgRead = !wr;
      cfgAddr = a;
      cfgByteEn = be;
      cfgWrData = d;
      @(negedge mclk);
      ok = cfgAck;
      rd = cfgRdData;
      cfgWrite = 1'b0;
      cfgRead = 1'b0;
      // released lines show junk, not the last value
      cfgAddr = ~a;
      cfgWrData = ~d;
   endtask
endmodule

// ===== tb/pci_config_space_regs_asserts.sv
// concurrent checks on the configuration register bank ports
// assumes binding onto the bank; one clock domain, sync active-low reset
module pci_config_space_regs_asserts (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // configuration access
   input wire logic cfgWrite,
   input wire logic cfgRead,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   input wire logic [31:0] cfgRdData,
   input wire logic cfgAck,
   // bus events
   input wire logic parityErrDetected,
   input wire logic addrParityErr,
   input wire logic perrSeenAsMaster,
   // control outputs
   input wire logic ioSpaceEnable,
   input wire logic memSpaceEnable,
   input wire logic busMasterEnable,
   input wire logic systemErrorDrive,
   input wire logic hostSysErrSet
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   // ****
   // access handshake and read values
   // ****
   ack_after_req_a: assert property ((cfgRead || cfgWrite) |=> cfgAck)
      else $error("access not acknowledged");
   ack_only_req_a: assert property (cfgAck |-> $past(cfgRead || cfgWrite))
      else $error("acknowledge without access");
   rsvd_read_zero_a: assert property (cfgRead && cfgAddr >= cfg_space_pkg::OFF_RSVD_LO
      && cfgAddr <= cfg_space_pkg::OFF_RSVD_HI |=> cfgRdData == cfg_space_pkg::ZERO32)
      else $error("reserved read not zero");
   id_fixed_a: assert property (cfgRead && cfgAddr == cfg_space_pkg::OFF_ID |=>
      cfgRdData == {cfg_space_pkg::DEVICE_ID, cfg_space_pkg::VENDOR_ID})
      else $error("identification value wrong");
   devsel_fixed_a: assert property (cfgRead && cfgAddr == cfg_space_pkg::OFF_CMDSTAT |=>
      cfgRdData[26:25] == cfg_space_pkg::DEVSEL_MEDIUM && cfgRdData[23])
      else $error("fixed status bits wrong");
   undef_zero_a: assert property (cfgRead && cfgAddr == cfg_space_pkg::OFF_CMDSTAT |=>
      (cfgRdData & 32'h087FFEB8) == 32'h00000000)
      else $error("undefined bits not zero");
   // ****
   // command enables and event outputs
   // ****
   io_enable_a: assert property (cfgWrite && cfgAddr == cfg_space_pkg::OFF_CMDSTAT
      && cfgByteEn[0] |-> ##2 ioSpaceEnable == $past(cfgWrData[0], 2))
      else $error("io enable does not follow write");
   mem_enable_a: assert property (cfgWrite && cfgAddr == cfg_space_pkg::OFF_CMDSTAT
      && cfgByteEn[0] |-> ##2 memSpaceEnable == $past(cfgWrData[1], 2))
      else $error("memory enable does not follow write");
   master_enable_a: assert property (cfgWrite && cfgAddr == cfg_space_pkg::OFF_CMDSTAT
      && cfgByteEn[0] |-> ##2 busMasterEnable == $past(cfgWrData[2], 2))
      else $error("master enable does not follow write");
   serr_cause_a: assert property (systemErrorDrive |-> $past(addrParityErr))
      else $error("system error without address parity error");
   host_err_cause_a: assert property (hostSysErrSet |->
      $past(parityErrDetected || addrParityErr || perrSeenAsMaster))
      else $error("host error without parity error");
   // main scenarios reached
   cover property (cfgRead && cfgAddr == cfg_space_pkg::OFF_RSVD_LO);
   cover property (systemErrorDrive);
   cover property (hostSysErrSet);
endmodule
bind pci_config_space_regs pci_config_space_regs_asserts pci_config_space_regs_asserts_i (
   .mclk(mclk), .rst_n(rst_n), .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr),
   .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgAck(cfgAck),
   .parityErrDetected(parityErrDetected), .addrParityErr(addrParityErr),
   .perrSeenAsMaster(perrSeenAsMaster), .ioSpaceEnable(ioSpaceEnable),
   .memSpaceEnable(memSpaceEnable), .busMasterEnable(busMasterEnable),
   .systemErrorDrive(systemErrorDrive), .hostSysErrSet(hostSysErrSet));

// ===== tb/tb_top.sv
// self-checking bench for the configuration register bank
// assumes the host model drives config cycles; events driven here at the falling edge
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] ev = 5'h00;
   logic cfgWrite, cfgRead, cfgAck, ioSpaceEnable, memSpaceEnable, busMasterEnable;
   logic systemErrorDrive, hostSysErrSet, ok;
   logic [7:0] cfgAddr;
   logic [3:0] cfgByteEn;
   logic [31:0] cfgWrData, cfgRdData, rd;
   logic [1:0] pz;
   logic [7:0] latencyTimer, interruptLine;
   logic [31:0] ioBase, memBase, driverArea;
   int failures = 0;
   int total_checks = 0;
   // writable registers plus the read-only revision word at 08, and their all-ones readback
   logic [7:0] addrs [6] = '{8'h0C, 8'h10, 8'h14, 8'h3C, 8'h40, 8'h08};
   logic [31:0] ones [6] = '{32'h0000FF00, 32'hFFFFFF81, 32'hFFFFFF80, 32'h000001FF,
                             32'hFFFFFFFF, cfg_space_pkg::REV_VALUE};
   // 25 MHz clock
   always #20 mclk = ~mclk;
   cfg_host_model cfg_host_model_i (.mclk(mclk), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
      .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
      .cfgRdData(cfgRdData), .cfgAck(cfgAck));
   pci_config_space_regs pci_config_space_regs_i (.mclk(mclk), .rst_n(rst_n),
      .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
      .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgAck(cfgAck),
      .parityErrDetected(ev[0]), .addrParityErr(ev[1]), .perrSeenAsMaster(ev[2]),
      .masterAbortSeen(ev[3]), .targetAbortSeen(ev[4]), .ioSpaceEnable(ioSpaceEnable),
      .memSpaceEnable(memSpaceEnable), .busMasterEnable(busMasterEnable),
      .systemErrorDrive(systemErrorDrive), .hostSysErrSet(hostSysErrSet),
      .latencyTimer(latencyTimer), .ioBase(ioBase), .memBase(memBase),
      .interruptLine(interruptLine), .driverArea(driverArea));
   // ****
   // access and compare tasks
   // ****
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      cfg_host_model_i.xfer(1'b1, a, be, d, rd, ok);
      chk({31'h0, ok}, 32'h1);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      cfg_host_model_i.xfer(1'b0, a, 4'hF, 32'h0, rd, ok);
      chk({31'h0, ok}, 32'h1);
      chk(rd, exp);
   endtask
   // one-cycle event pulse; output pulses caught in the following cycle
   task automatic pulse(input int n);
      @(negedge mclk);
      ev[n] = 1'b1;
      @(negedge mclk);
      pz = {systemErrorDrive, hostSysErrSet};
      ev = 5'h00;
   endtask
   task automatic conclude();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ****
   // test sequence
   // ****
   initial begin
      repeat (5) @(negedge mclk);
      rst_n = 1'b1;
      rdc(8'h04, cfg_space_pkg::CMDSTAT_RESET);
      wr(8'h00, 4'hF, 32'hFFFFFFFF);
      rdc(8'h00, {cfg_space_pkg::DEVICE_ID, cfg_space_pkg::VENDOR_ID});
      for (int a = 8'h18; a <= 8'h38; a += 4) begin
         wr(8'(a), 4'hF, 32'hFFFFFFFF);
         rdc(8'(a), 32'h0);
      end
      rdc(8'h44, 32'h0);
      foreach (addrs[i]) begin
         wr(addrs[i], 4'hF, 32'hFFFFFFFF);
         rdc(addrs[i], ones[i]);
      end
      // register copies seen by the rest of the controller
      chk({24'h0, latencyTimer}, 32'h000000FF);
      chk(ioBase, 32'hFFFFFF81);
      chk(memBase, 32'hFFFFFF80);
      chk({24'h0, interruptLine}, 32'h000000FF);
      chk(driverArea, 32'hFFFFFFFF);
      // middle lanes of a stored word only
      wr(8'h40, 4'h6, 32'h0);
      rdc(8'h40, 32'hFF0000FF);
      chk(driverArea, 32'hFF0000FF);
      wr(8'h04, 4'hF, 32'hFFFFFFFF);
      rdc(8'h04, 32'h02800147);
      chk({29'h0, busMasterEnable, memSpaceEnable, ioSpaceEnable}, 32'h7);
      wr(8'h04, 4'h1, 32'h0);
      rdc(8'h04, 32'h02800100);
      chk({29'h0, busMasterEnable, memSpaceEnable, ioSpaceEnable}, 32'h0);
      // events with parity response off, then on; system error enable on
      pulse(0);
      chk({30'h0, pz}, 32'h0);
      pulse(2);
      pulse(3);
      pulse(4);
      pulse(1);
      chk({30'h0, pz}, 32'h2);
      rdc(8'h04, 32'hF2800100);
      rdc(8'h04, 32'hF2800100);
      wr(8'h04, 4'h1, 32'h40);
      pulse(2);
      pulse(0);
      chk({30'h0, pz}, 32'h1);
      rdc(8'h04, 32'hF3800140);
      // write-one-to-clear on the top byte, zeros keep
      wr(8'h04, 4'h8, 32'hA0000000);
      rdc(8'h04, 32'h53800140);
      wr(8'h04, 4'h8, 32'h51000000);
      rdc(8'h04, 32'h02800140);
      wr(8'h04, 4'h3, 32'h0);
      rdc(8'h04, 32'h02800000);
      chk({29'h0, busMasterEnable, memSpaceEnable, ioSpaceEnable}, 32'h0);
      // hardware reset in mid-run returns reset values; dirty the state first
      wr(8'h04, 4'h3, 32'h00000147);
      pulse(3);
      @(negedge mclk);
      rst_n = 1'b0;
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      rdc(8'h0C, cfg_space_pkg::LAT_RESET);
      rdc(8'h10, 32'h00000001);
      rdc(8'h04, cfg_space_pkg::CMDSTAT_RESET);
      chk({29'h0, busMasterEnable, memSpaceEnable, ioSpaceEnable}, 32'h0);
      chk(ioBase, 32'h00000001);
      conclude();
   end
   // watchdog sized well beyond the roughly 130 cycles the sequence needs
   initial begin
      #200000;
      failures++;
      conclude();
   end
endmodule
